// File: core/mcr_pkg.sv
// Constants for the MCU control register bank: offsets, fields, resets, timing.
// Assumes an 8-bit register port on the peripheral clock.
package mcr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam int unsigned MCR_ADDR_W = 8;
    localparam int unsigned MCR_DATA_W = 8;
    localparam logic [7:0] MCR_OFF_VENDOR = 8'h00;
    localparam logic [7:0] MCR_OFF_FLASH = 8'h01;
    localparam logic [7:0] MCR_OFF_PART = 8'h02;
    localparam logic [7:0] MCR_OFF_REV = 8'h03;
    localparam logic [7:0] MCR_OFF_ANA = 8'h07;
    localparam logic [7:0] MCR_OFF_EVLOCK = 8'h08;
    localparam logic [7:0] MCR_OFF_WXLOCK = 8'h09;
    localparam logic [7:0] MCR_OFF_CCP = 8'h0a;

    // ------------------------------------------------------------
    // Identity values (arbitrary, neutral)
    // ------------------------------------------------------------
    localparam logic [7:0] MCR_VENDOR_CODE = 8'h5a;  // Arbitrary value
    localparam logic [7:0] MCR_FLASH_CODE = 8'h93;   // Arbitrary value
    localparam logic [7:0] MCR_PART_CODE = 8'h4c;    // Arbitrary value
    localparam logic [3:0] MCR_REV_CODE = 4'h1;      // Arbitrary value

    // ------------------------------------------------------------
    // Fields and resets
    // ------------------------------------------------------------
    localparam int unsigned MCR_REV_W = 4;
    localparam int unsigned MCR_DLY_W = 2;
    localparam logic [1:0] MCR_DLY_RST = 2'h0;
    localparam logic [1:0] MCR_DLY_NONE = 2'h0;
    localparam logic [1:0] MCR_DLY_2 = 2'h1;
    localparam logic [1:0] MCR_DLY_8 = 2'h2;
    localparam logic [1:0] MCR_DLY_32 = 2'h3;
    localparam logic [7:0] MCR_RD_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Protection key and timing
    // ------------------------------------------------------------
    localparam logic [7:0] MCR_CCP_KEY = 8'hd8;
    localparam int unsigned MCR_CCP_WINDOW = 4;
    localparam int unsigned MCR_CLK_HZ = 20_000_000;
    localparam int unsigned MCR_GAP_2 = 2;
    localparam int unsigned MCR_GAP_8 = 8;
    localparam int unsigned MCR_GAP_32 = 32;
    localparam int unsigned MCR_CNT_W = 6;
    localparam int unsigned MCR_STEPS = 3;

endpackage

// File: core/mcr_ctrl_regs.sv
// MCU control register bank: identification bytes, analog start-up
// sequencer and two protected lock bits.
// Assumes a single-master register port; reads answer the next cycle.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

// Behaviour
// [R1] Offset zero always reads fixed vendor code
// [R2] Offset one reads fixed flash size code
// [R3] Offset two reads fixed part number code
// [R4] Revision low nibble, upper nibble reads zero
// [R5] Software writes zero to unused upper bits
// [R6] Nonzero delay staggers analog start steps
// [R7] Codes 00 none, 10 eight, 11 thirty-two
// [R8] Code 01 gives two-cycle spacing
// [R9] Software picks spacing above half microsecond
// [R10] Event lock bit freezes channels zero-three config
// [R11] Waveform lock bit freezes timer C0 extension
// [R12] Lock writes need protection unlock first
// [R13] Reset clears fields; locks sticky until reset
module mcr_ctrl_regs #(
    parameter int unsigned STEPS = mcr_pkg::MCR_STEPS,
    parameter int unsigned CCP_WINDOW = mcr_pkg::MCR_CCP_WINDOW
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [mcr_pkg::MCR_ADDR_W-1:0] i_addr,
    input wire logic [mcr_pkg::MCR_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [mcr_pkg::MCR_DATA_W-1:0] o_rdata,
    input wire logic i_ana_enable,
    output logic [STEPS-1:0] o_ana_start,
    output logic o_ana_ready,
    output logic o_event_group0_lock_bit,
    output logic o_waveform_ext_c0_lock_bit,
    input wire logic i_evt_cfg_wr,
    output logic o_evt_cfg_wr_allow,
    input wire logic i_wex_cfg_wr,
    output logic o_wex_cfg_wr_allow
);
    import mcr_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Stage index is compared on four bits; the check still caps the stages at eight
    initial begin
        if (STEPS < 1 || STEPS > 8) begin
            $error("STEPS must be 1 to 8");
        end
        // Window count must fit the down-counter
        if (CCP_WINDOW < 1 || CCP_WINDOW > 63) begin
            $error("CCP_WINDOW must be 1 to 63");
        end
        if (MCR_GAP_32 >= (32'd1 << MCR_CNT_W)) begin
            $error("Gap counter too narrow for longest spacing");
        end
        if (MCR_GAP_2 < 1) begin
            $error("Shortest spacing must be at least one cycle");
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MCR_IDLE,
        MCR_WAIT,
        MCR_DONE
    } mcr_seq_e;

    logic [MCR_DLY_W-1:0] dly_q;
    logic ev_lock_q;
    logic wx_lock_q;
    logic [MCR_CNT_W-1:0] ccp_cnt_q;
    logic ccp_open;
    logic [MCR_DATA_W-1:0] rdata_q;
    mcr_seq_e seq_q;
    logic [MCR_CNT_W-1:0] gap_q;
    logic [MCR_CNT_W-1:0] gap_len;
    logic [3:0] step_q;
    logic [STEPS-1:0] start_q;
    logic [MCR_CNT_W-1:0] ccp_cnt_d;
    logic [MCR_DLY_W-1:0] dly_d;
    logic ev_lock_d;
    logic wx_lock_d;
    logic gap_done;
    logic fire_all;
    logic fire_one;
    logic [3:0] fire_idx;
    logic last_step;

    assign ccp_open = (ccp_cnt_q != '0);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_key;
    logic wr_ana;
    logic wr_ev;
    logic wr_wx;
    logic wr_any;

    assign wr_any = i_wr;
    assign wr_key = i_wr && (i_addr == MCR_OFF_CCP) && (i_wdata == MCR_CCP_KEY);
    assign wr_ana = i_wr && (i_addr == MCR_OFF_ANA);
    // Lock writes count only while the protection window is open
    assign wr_ev = i_wr && (i_addr == MCR_OFF_EVLOCK) && ccp_open;  // see [R12]
    assign wr_wx = i_wr && (i_addr == MCR_OFF_WXLOCK) && ccp_open;  // see [R12]

    // ------------------------------------------------------------
    // Configuration change protection
    // ------------------------------------------------------------
    // Key write opens a short window; any other write closes it
    always_comb begin
        ccp_cnt_d = ccp_cnt_q;
        if (wr_key) begin
            ccp_cnt_d = MCR_CNT_W'(CCP_WINDOW);  // see [R12]
        end else if (wr_any) begin
            ccp_cnt_d = '0;
        end else if (ccp_open) begin
            ccp_cnt_d = ccp_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ccp_cnt_q <= '0;
        end else begin
            ccp_cnt_q <= ccp_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    // Upper bits are dropped; software keeps them zero, see [R5]
    assign dly_d = wr_ana ? i_wdata[MCR_DLY_W-1:0] : dly_q;
    // Locks only set, so a later write of zero cannot release them
    assign ev_lock_d = ev_lock_q || (wr_ev && i_wdata[0]);  // see [R12]
    assign wx_lock_d = wx_lock_q || (wr_wx && i_wdata[0]);  // see [R12]

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            dly_q <= MCR_DLY_RST;  // see [R13]
        end else begin
            dly_q <= dly_d;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ev_lock_q <= 1'b0;  // see [R13]
        end else begin
            ev_lock_q <= ev_lock_d;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            wx_lock_q <= 1'b0;  // see [R13]
        end else begin
            wx_lock_q <= wx_lock_d;
        end
    end

    // ------------------------------------------------------------
    // Lock gates
    // ------------------------------------------------------------
    assign o_event_group0_lock_bit = ev_lock_q;
    assign o_waveform_ext_c0_lock_bit = wx_lock_q;
    assign o_evt_cfg_wr_allow = i_evt_cfg_wr && !ev_lock_q;  // see [R10]
    assign o_wex_cfg_wr_allow = i_wex_cfg_wr && !wx_lock_q;  // see [R11]

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [MCR_DATA_W-1:0] rd_mux;

    // Unmapped offsets read as zero
    always_comb begin
        rd_mux = MCR_RD_UNMAPPED;
        case (i_addr)
            MCR_OFF_VENDOR: begin
                rd_mux = MCR_VENDOR_CODE;  // see [R1]
            end
            MCR_OFF_FLASH: begin
                rd_mux = MCR_FLASH_CODE;  // see [R2]
            end
            MCR_OFF_PART: begin
                rd_mux = MCR_PART_CODE;  // see [R3]
            end
            MCR_OFF_REV: begin
                rd_mux = {4'h0, MCR_REV_CODE};  // see [R4]
            end
            MCR_OFF_ANA: begin
                rd_mux = {6'h00, dly_q};
            end
            MCR_OFF_EVLOCK: begin
                rd_mux = {7'h00, ev_lock_q};
            end
            MCR_OFF_WXLOCK: begin
                rd_mux = {7'h00, wx_lock_q};
            end
            MCR_OFF_CCP: begin
                rd_mux = {7'h00, ccp_open};
            end
            default: begin
                rd_mux = MCR_RD_UNMAPPED;
            end
        endcase
    end

    // Data stands one cycle after the strobe, then drops to zero
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rdata_q <= '0;
        end else if (i_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= '0;
        end
    end

    assign o_rdata = rdata_q;

    // ------------------------------------------------------------
    // Analog start-up sequencer
    // ------------------------------------------------------------
    // Spacing codes map to cycle counts between stage starts
    always_comb begin
        gap_len = '0;
        case (dly_q)
            MCR_DLY_NONE: begin
                gap_len = '0;  // see [R7]
            end
            MCR_DLY_2: begin
                gap_len = MCR_CNT_W'(MCR_GAP_2);  // see [R8]
            end
            MCR_DLY_8: begin
                gap_len = MCR_CNT_W'(MCR_GAP_8);  // see [R7]
            end
            MCR_DLY_32: begin
                gap_len = MCR_CNT_W'(MCR_GAP_32);  // see [R7]
            end
            default: begin
                gap_len = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Stage firing decode
    // ------------------------------------------------------------
    // All stages at once, or one per elapsed gap
    assign gap_done = (gap_q <= MCR_CNT_W'(1));
    assign fire_all = i_ana_enable && (seq_q == MCR_IDLE) && (dly_q == MCR_DLY_NONE);
    assign fire_one = i_ana_enable
        && (((seq_q == MCR_IDLE) && (dly_q != MCR_DLY_NONE))
        || ((seq_q == MCR_WAIT) && gap_done));  // see [R6]
    assign fire_idx = (seq_q == MCR_IDLE) ? 4'h0 : step_q;
    assign last_step = (32'(fire_idx) + 32'd1) >= STEPS;

    // Dropping enable returns to idle at once
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            seq_q <= MCR_IDLE;
        end else if (!i_ana_enable) begin
            seq_q <= MCR_IDLE;
        end else begin
            case (seq_q)
                MCR_IDLE: begin
                    if (fire_all || last_step) begin
                        seq_q <= MCR_DONE;
                    end else begin
                        seq_q <= MCR_WAIT;
                    end
                end
                MCR_WAIT: begin
                    if (fire_one && last_step) begin
                        seq_q <= MCR_DONE;
                    end
                end
                MCR_DONE: begin
                    seq_q <= MCR_DONE;
                end
                default: begin
                    seq_q <= MCR_IDLE;
                end
            endcase
        end
    end

    // Index of the next stage to start
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            step_q <= '0;
        end else if (!i_ana_enable) begin
            step_q <= '0;
        end else if (fire_one) begin
            step_q <= fire_idx + 4'h1;
        end
    end

    // Reloads on every start, so a new code applies to later gaps
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            gap_q <= '0;
        end else if (!i_ana_enable) begin
            gap_q <= '0;
        end else if (fire_one) begin
            gap_q <= gap_len;
        end else if (seq_q == MCR_WAIT) begin
            gap_q <= gap_q - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Stage flops
    // ------------------------------------------------------------
    // One flop per stage; stays on until enable drops
    for (genvar k = 0; k < STEPS; k++) begin : g_stage
        logic stage_q;
        always_ff @(posedge i_clk_sys) begin
            if (i_sys_rst) begin
                stage_q <= 1'b0;
            end else if (!i_ana_enable) begin
                stage_q <= 1'b0;
            end else if (fire_all || (fire_one && fire_idx == 4'(k))) begin
                stage_q <= 1'b1;  // see [R6]
            end
        end
        assign start_q[k] = stage_q;
    end

    assign o_ana_start = start_q;
    assign o_ana_ready = (seq_q == MCR_DONE);

endmodule

// File: verification/mcr_ctrl_regs_assertions.sv
// Checker for the control register bank, bound onto its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module mcr_ctrl_regs_chk #(
    parameter int unsigned STEPS = 3
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_ana_enable,
    input wire logic [STEPS-1:0] o_ana_start,
    input wire logic o_ana_ready,
    input wire logic o_event_group0_lock_bit,
    input wire logic i_evt_cfg_wr,
    input wire logic o_evt_cfg_wr_allow
);
    import mcr_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    chk_id_vendor:
    assert property (i_rd && i_addr == 0 |=> o_rdata == MCR_VENDOR_CODE) else $error("id0");
    chk_id_flash:
    assert property (i_rd && i_addr == 1 |=> o_rdata == MCR_FLASH_CODE) else $error("id1");
    chk_rev_upper:
    assert property (i_rd && i_addr == 3 |=> o_rdata == {4'h0, MCR_REV_CODE}) else $error("rev");
    chk_evt_gate:
    assert property (o_evt_cfg_wr_allow == (i_evt_cfg_wr && !o_event_group0_lock_bit))
        else $error("gate");
    chk_lock_sticky:
    assert property (o_event_group0_lock_bit |=> o_event_group0_lock_bit) else $error("stick");
    chk_lock_cause:
    assert property ($rose(o_event_group0_lock_bit) |-> $past(i_wr) && $past(i_addr) == 8)
        else $error("cause");
    chk_ready_all:
    assert property (o_ana_ready |-> &o_ana_start) else $error("ready");
    chk_enable_drop:
    assert property ($fell(i_ana_enable) |=> o_ana_start == '0 && !o_ana_ready) else $error("off");
    cover property ($rose(o_event_group0_lock_bit));
    cover property ($rose(o_ana_ready));
    cover property (i_rd && i_addr == 3);
endmodule

// File: verification/tb.sv
// Bench: register traffic and start-up sequencing against a table model.
// Assumes the checker module is compiled ahead of this file.
`timescale 1ns/1ps
module tb;
    import mcr_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, en = 0, ew = 0, rdy, ea, xa, el, xl;
    logic [7:0] addr = 0, wd = 0, rdata;
    logic [2:0] st;
    int failures = 0, checks_done = 0, cyc = 0, gap[4] = '{0, 2, 8, 32};
    logic [7:0] m[16] = '{0: MCR_VENDOR_CODE, 1: MCR_FLASH_CODE, 2: MCR_PART_CODE,
        3: {4'h0, MCR_REV_CODE}, default: 8'h00};
    always #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) if (cyc == 2500) wrap_up(1);
    mcr_ctrl_regs mcr_ctrl_regs_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr),
        .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ana_enable(en),
        .o_ana_start(st), .o_ana_ready(rdy), .o_event_group0_lock_bit(el),
        .o_waveform_ext_c0_lock_bit(xl), .i_evt_cfg_wr(ew), .o_evt_cfg_wr_allow(ea),
        .i_wex_cfg_wr(ew), .o_wex_cfg_wr_allow(xa));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        failures += (g !== e);
        if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {wr, rd} <= {w, !w};
        addr <= a;
        wd <= d;
        // Random config requests so the gates are seen both open and shut
        ew <= 1'($urandom);
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1;
        if (!w) chk(rdata, m[a]);
    endtask
    task automatic seq(input int g);
        @(posedge clk);
        en <= 1;
        for (int t = 1; t < 70; t++) @(posedge clk) #1
            chk(8'({rdy, st}), 8'({t > 2 * g, t > 2 * g, t > g, 1'b1}));
        @(posedge clk);
        en <= 0;
    endtask
    task automatic wrap_up(input int late);
        failures += late;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hf85a258e));
        repeat (8) @(posedge clk);
        rst <= 0;
        for (int a = 0; a < 16; a++) bus(0, 8'(a), 8'h00);
        for (int a = 0; a < 4; a++) bus(1, 8'(a), 8'($urandom));
        bus(1, 8'h08, 8'h01);
        bus(0, 8'h08, 8'h00);
        chk(8'({el, xl, ea, xa}), 8'({2'b00, ew, ew}));
        for (int a = 8; a < 10; a++) begin
            bus(1, MCR_OFF_CCP, MCR_CCP_KEY);
            bus(1, 8'(a), 8'h01);
            m[a] = 8'h01;
            bus(0, 8'(a), 8'h00);
        end
        chk(8'({el, xl, ea, xa}), 8'h0c);
        bus(1, MCR_OFF_CCP, MCR_CCP_KEY);
        bus(1, 8'h08, 8'h00);
        bus(0, 8'h08, 8'h00);
        for (int c = 0; c < 4; c++) begin
            bus(1, 8'h07, 8'(c));
            m[7] = 8'(c);
            bus(0, 8'h07, 8'h00);
            seq(gap[c]);
        end
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        m[7:9] = '{8'h00, 8'h00, 8'h00};
        for (int a = 0; a < 16; a++) bus(0, 8'(a), 8'h00);
        chk(8'({el, xl}), 8'h00);
        wrap_up(0);
    end
endmodule
bind mcr_ctrl_regs mcr_ctrl_regs_chk #(.STEPS(STEPS)) mcr_ctrl_regs_chk_i (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ana_enable(i_ana_enable), .o_ana_start(o_ana_start),
    .o_ana_ready(o_ana_ready), .o_event_group0_lock_bit(o_event_group0_lock_bit),
    .i_evt_cfg_wr(i_evt_cfg_wr), .o_evt_cfg_wr_allow(o_evt_cfg_wr_allow));
